// file: rtl/sensor_readout_regs.vh
// Summary of operation
// - Command bits sampled, data bits launched, on serial clock rising edges.
// - Data output carries result, calibration word or status per last command.
// - Seven commands: pressure, temperature, four calibration words, reset.
// - Every transaction except the reset pattern opens with three high bits on the command input.
// - Four setup bits follow the start group and select the operation.
// - Three low stop bits follow every setup field.
// - Conversion start is acknowledged by data output going low to high.
// - End of conversion is data output high to low; host waits for it.
// - Host gives 17 clocks to read the 16-bit result.
// - Host may pause readout; device resumes at the same bit.
// - The 21-bit reset pattern is recognised in any state and resyncs.
// - Calibration data lives in a 64-bit read-only memory.
// - Calibration memory reads as four 16-bit words, one per command.
// - Pressure and temperature results are 16-bit raw values.
`ifndef SENSOR_READOUT_REGS_VH
`define SENSOR_READOUT_REGS_VH
// ***************************************************************
// Command codes and patterns
// ***************************************************************
`define SETUP_PRESSURE     4'hA
`define SETUP_TEMPERATURE  4'h9
`define SETUP_CAL_ONE      4'h5
`define SETUP_CAL_TWO      4'h6
`define SETUP_CAL_THREE    4'h3
`define SETUP_CAL_FOUR     4'hC
`define RESET_PATTERN      21'h155540
`define RESET_LEN          5'h15
`define START_LEN          3'h3
`define SETUP_LEN          3'h4
`define STOP_LEN           3'h3
`define ACK_CLOCKS         2'h2
`define RESULT_CLOCKS      5'h11
// ***************************************************************
// Calibration memory and conversion timing
// ***************************************************************
`define CAL_ROM_VALUE      64'h0123456789ABCDEF
`define CONV_MCLK_EDGES    16'h0480
`define DATA_IDLE          1'b0
`endif

// file: rtl/word_buffer.v
`timescale 1ns/1ns
`default_nettype none
module word_buffer (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Fill side
	input  wire        in_valid,
	output wire        in_ready,
	input  wire [15:0] in_data,
	// Drain side
	output wire        out_valid,
	input  wire        out_ready,
	output wire [15:0] out_data
);
	reg [15:0] mem_r [0:1];
	reg        wr_r;
	reg        rd_r;
	reg [1:0]  cnt_r;
	wire       push;
	wire       pop;
	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always @(posedge clk) begin
		if (!rst_n) begin
			wr_r     <= 1'b0;
			rd_r     <= 1'b0;
			cnt_r    <= 2'h0;
			mem_r[0] <= 16'h0000;
			mem_r[1] <= 16'h0000;
		end else begin
			if (push) begin
				mem_r[wr_r] <= in_data;
				wr_r        <= ~wr_r;
			end
			if (pop)
				rd_r <= ~rd_r;
			if (push && !pop)
				cnt_r <= cnt_r + 2'h1;
			else if (pop && !push)
				cnt_r <= cnt_r - 2'h1;
		end
	end
endmodule
`default_nettype wire

// file: rtl/pressure_sensor_serial_readout.v
`timescale 1ns/1ns
`default_nettype none
`include "sensor_readout_regs.vh"
module pressure_sensor_serial_readout (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Serial link pins
	input  wire        serial_clock,
	input  wire        command_in,
	output wire        sensor_data_out,
	// Conversion master clock pin
	input  wire        conversion_master_clock,
	// Converter data inputs
	input  wire [15:0] pressure_raw,
	input  wire [15:0] temperature_raw,
	// Status
	output wire        busy
);
	// ***************************************************************
	// Pin synchronisers and edge detection
	// ***************************************************************
	reg [1:0] sck_s_r;
	reg [1:0] din_s_r;
	reg [1:0] mck_s_r;
	reg       sck_d_r;
	reg       mck_d_r;
	always @(posedge clk) begin
		if (!rst_n) begin
			sck_s_r <= 2'h0;
			din_s_r <= 2'h0;
			mck_s_r <= 2'h0;
			sck_d_r <= 1'b0;
			mck_d_r <= 1'b0;
		end else begin
			sck_s_r <= {sck_s_r[0], serial_clock};
			din_s_r <= {din_s_r[0], command_in};
			mck_s_r <= {mck_s_r[0], conversion_master_clock};
			sck_d_r <= sck_s_r[1];
			mck_d_r <= mck_s_r[1];
		end
	end
	wire sck_rise = sck_s_r[1] && !sck_d_r;
	wire mck_rise = mck_s_r[1] && !mck_d_r;
	wire din_bit  = din_s_r[1];
	// ***************************************************************
	// Protocol states
	// ***************************************************************
	localparam ST_IDLE  = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_SETUP = 3'h2;
	localparam ST_STOP  = 3'h3;
	localparam ST_ACK   = 3'h4;
	localparam ST_CONV  = 3'h5;
	localparam ST_LOAD  = 3'h6;
	localparam ST_SHIFT = 3'h7;
	reg [2:0]  state_r;
	reg [2:0]  state_nxt;
	reg [2:0]  cnt_r;
	reg [2:0]  cnt_nxt;
	reg [3:0]  setup_r;
	reg [3:0]  setup_nxt;
	reg [4:0]  bits_r;
	reg [4:0]  bits_nxt;
	reg [15:0] shift_r;
	reg [15:0] shift_nxt;
	reg        dout_r;
	reg        dout_nxt;
	reg        conv_r;
	reg        conv_nxt;
	reg [15:0] mck_cnt_r;
	reg [15:0] mck_cnt_nxt;
	reg [20:0] rst_hist_r;
	reg        push;
	reg        pop;
	reg [15:0] push_data;
	wire       buf_in_ready;
	wire       buf_out_valid;
	wire [15:0] buf_out_data;
	// Calibration memory, four words
	wire [63:0] cal_rom = `CAL_ROM_VALUE;
	wire [15:0] cal_word [0:3];
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cal
			assign cal_word[gi] = cal_rom[63 - 16 * gi -: 16];
		end
	endgenerate
	// Reset pattern watcher over every sampled bit
	wire rst_seen = ({rst_hist_r[19:0], din_bit} == `RESET_PATTERN);
	always @(posedge clk) begin
		if (!rst_n)
			rst_hist_r <= 21'h000000;
		else if (sck_rise)
			rst_hist_r <= {rst_hist_r[19:0], din_bit};
	end
	// ***************************************************************
	// Next-state logic
	// ***************************************************************
	always @* begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		setup_nxt   = setup_r;
		bits_nxt    = bits_r;
		shift_nxt   = shift_r;
		dout_nxt    = dout_r;
		conv_nxt    = conv_r;
		mck_cnt_nxt = mck_cnt_r;
		push        = 1'b0;
		pop         = 1'b0;
		push_data   = 16'h0000;
		if (sck_rise && rst_seen) begin
			state_nxt = ST_IDLE;
			cnt_nxt   = 3'h0;
			dout_nxt  = `DATA_IDLE;
			conv_nxt  = 1'b0;
		end else begin
			case (state_r)
			ST_IDLE: begin
				dout_nxt = `DATA_IDLE;
				if (sck_rise && din_bit) begin
					state_nxt = ST_START;
					cnt_nxt   = 3'h1;
				end
			end
			ST_START: if (sck_rise) begin
				if (!din_bit) begin
					state_nxt = ST_IDLE;
				end else if (cnt_r + 3'h1 == `START_LEN) begin
					state_nxt = ST_SETUP;
					cnt_nxt   = 3'h0;
				end else begin
					cnt_nxt = cnt_r + 3'h1;
				end
			end
			ST_SETUP: if (sck_rise) begin
				setup_nxt = {setup_r[2:0], din_bit};
				cnt_nxt   = cnt_r + 3'h1;
				if (cnt_r + 3'h1 == `SETUP_LEN) begin
					state_nxt = ST_STOP;
					cnt_nxt   = 3'h0;
				end
			end
			ST_STOP: if (sck_rise) begin
				if (din_bit) begin
					state_nxt = ST_IDLE;
				end else if (cnt_r + 3'h1 == `STOP_LEN) begin
					cnt_nxt = 3'h0;
					case (setup_r)
					`SETUP_PRESSURE, `SETUP_TEMPERATURE: begin
						state_nxt = ST_ACK;
						dout_nxt  = 1'b1;
						conv_nxt  = 1'b1;
						mck_cnt_nxt = 16'h0000;
					end
					`SETUP_CAL_ONE, `SETUP_CAL_TWO, `SETUP_CAL_THREE,
					`SETUP_CAL_FOUR: begin
						state_nxt = ST_LOAD;
						push      = buf_in_ready;
						case (setup_r)
						`SETUP_CAL_ONE:   push_data = cal_word[0];
						`SETUP_CAL_TWO:   push_data = cal_word[1];
						`SETUP_CAL_THREE: push_data = cal_word[2];
						default:          push_data = cal_word[3];
						endcase
					end
					default: state_nxt = ST_IDLE;
					endcase
				end else begin
					cnt_nxt = cnt_r + 3'h1;
				end
			end
			ST_ACK: begin
				// Conversion runs from the acknowledge, link clock or not
				if (mck_rise)
					mck_cnt_nxt = mck_cnt_r + 16'h0001;
				if (sck_rise) begin
					cnt_nxt = cnt_r + 3'h1;
					if (cnt_r + 3'h1 == {1'b0, `ACK_CLOCKS})
						state_nxt = ST_CONV;
				end
			end
			ST_CONV: begin
				if (mck_rise)
					mck_cnt_nxt = mck_cnt_r + 16'h0001;
				if (mck_cnt_r == `CONV_MCLK_EDGES && buf_in_ready) begin
					push      = 1'b1;
					push_data = (setup_r == `SETUP_PRESSURE) ?
						pressure_raw : temperature_raw;
					dout_nxt  = 1'b0;
					conv_nxt  = 1'b0;
					state_nxt = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (buf_out_valid) begin
					pop       = 1'b1;
					shift_nxt = buf_out_data;
					bits_nxt  = 5'h00;
					state_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: if (sck_rise) begin
				bits_nxt = bits_r + 5'h01;
				if (bits_r < 5'h10) begin
					dout_nxt  = shift_r[15];
					shift_nxt = {shift_r[14:0], 1'b0};
				end else begin
					dout_nxt = `DATA_IDLE;
				end
				if (bits_r + 5'h01 == `RESULT_CLOCKS)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
			endcase
		end
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			state_r   <= ST_IDLE;
			cnt_r     <= 3'h0;
			setup_r   <= 4'h0;
			bits_r    <= 5'h00;
			shift_r   <= 16'h0000;
			dout_r    <= `DATA_IDLE;
			conv_r    <= 1'b0;
			mck_cnt_r <= 16'h0000;
		end else begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			setup_r   <= setup_nxt;
			bits_r    <= bits_nxt;
			shift_r   <= shift_nxt;
			dout_r    <= dout_nxt;
			conv_r    <= conv_nxt;
			mck_cnt_r <= mck_cnt_nxt;
		end
	end
	// ***************************************************************
	// Result buffer
	// ***************************************************************
	word_buffer word_buffer_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (buf_in_ready),
		.in_data   (push_data),
		.out_valid (buf_out_valid),
		.out_ready (pop),
		.out_data  (buf_out_data)
	);
	assign sensor_data_out = dout_r;
	assign busy            = conv_r;
endmodule
`default_nettype wire

// file: verif/sensor_readout_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "sensor_readout_regs.vh"
module sensor_readout_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched pins
	input wire logic serial_clock,
	input wire logic sensor_data_out,
	input wire logic conversion_master_clock,
	input wire logic busy
);
	localparam int LO = `CONV_MCLK_EDGES - 1;
	localparam int HI = `CONV_MCLK_EDGES + 2;
	logic        sc_r;
	logic        mc_r;
	logic [7:0]  gap_r;
	logic [15:0] mcnt_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ***************************************************************
	// Cycles since link clock rise, master clock rises while busy
	// ***************************************************************
	always_ff @(posedge clk) begin
		sc_r <= serial_clock;
		mc_r <= conversion_master_clock;
		if (!rst_n || (serial_clock && !sc_r))
			gap_r <= 8'h00;
		else if (gap_r != 8'hFF)
			gap_r <= gap_r + 8'h01;
		if (!busy)
			mcnt_r <= 16'h0000;
		else if (conversion_master_clock && !mc_r)
			mcnt_r <= mcnt_r + 16'h0001;
	end
	// ***************************************************************
	// Properties
	// ***************************************************************
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !sensor_data_out && !busy)
		else $error("output active after reset");
	a_out_on_rise: assert property ($changed(sensor_data_out) && !$fell(busy) |-> gap_r <= 8'h06)
		else $error("output moved without a link clock rise");
	a_busy_on_rise: assert property ($rose(busy) |-> gap_r <= 8'h06)
		else $error("conversion started without a link clock rise");
	a_ack_level: assert property (busy |-> sensor_data_out)
		else $error("output low during conversion");
	a_done_low: assert property ($fell(busy) |-> !sensor_data_out)
		else $error("output high at conversion end");
	a_conv_min: assert property ($fell(busy) && gap_r > 8'h06 |-> mcnt_r >= LO)
		else $error("conversion ended early");
	a_conv_max: assert property (busy |-> mcnt_r <= HI)
		else $error("conversion overran");
	a_busy_holds: assert property ($rose(busy) |=> busy[*8])
		else $error("conversion dropped at once");
endmodule
bind pressure_sensor_serial_readout sensor_readout_props sensor_readout_props_inst (
	.clk(clk),
	.rst_n(rst_n),
	.serial_clock(serial_clock),
	.sensor_data_out(sensor_data_out),
	.conversion_master_clock(conversion_master_clock),
	.busy(busy)
);
`default_nettype wire

// file: verif/sensor_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "sensor_readout_regs.vh"
module sensor_host_model (
	// Link pins
	output logic serial_clock,
	output logic command_in,
	output logic conversion_master_clock,
	input  wire logic sensor_data_out
);
	logic s;
	initial begin
		serial_clock = 1'b0;
		command_in = 1'b0;
		conversion_master_clock = 1'b0;
		forever #80 conversion_master_clock = ~conversion_master_clock;
	end
	// One link clock: change on fall, sample at next fall
	task automatic tick(input logic b);
		command_in = b;
		#40 serial_clock = 1'b1;
		#120 serial_clock = 1'b0;
		s = sensor_data_out;
	endtask
	task automatic send(input logic [20:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			tick(v[i]);
	endtask
	task automatic command(input logic [3:0] c);
		send({11'h000, 3'h7, c, 3'h0}, 10);
	endtask
	task automatic resync;
		send(`RESET_PATTERN, `RESET_LEN);
	endtask
	task automatic read_word(input int hold, output logic [15:0] w);
		for (int i = 0; i < 17; i++) begin
			if (i == 8)
				#hold;
			tick(1'b0);
			if (i < 16)
				w = {w[14:0], s};
		end
	endtask
endmodule
`default_nettype wire

// file: verif/pressure_sensor_serial_readout_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "sensor_readout_regs.vh"
module pressure_sensor_serial_readout_test;
	localparam logic [63:0] ROM = `CAL_ROM_VALUE;
	logic        clk;
	logic        rst_n;
	logic [15:0] pressure_raw;
	logic [15:0] temperature_raw;
	logic [15:0] w;
	wire         serial_clock;
	wire         command_in;
	wire         sensor_data_out;
	wire         conversion_master_clock;
	wire         busy;
	int          n_fail;
	int          num_checks;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	pressure_sensor_serial_readout pressure_sensor_serial_readout_inst (
		.clk(clk),
		.rst_n(rst_n),
		.serial_clock(serial_clock),
		.command_in(command_in),
		.sensor_data_out(sensor_data_out),
		.conversion_master_clock(conversion_master_clock),
		.pressure_raw(pressure_raw),
		.temperature_raw(temperature_raw),
		.busy(busy)
	);
	sensor_host_model sensor_host_model_inst (
		.serial_clock(serial_clock),
		.command_in(command_in),
		.conversion_master_clock(conversion_master_clock),
		.sensor_data_out(sensor_data_out)
	);
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_idle;
		sensor_host_model_inst.send(21'h000000, 12);
		check("idle out", 16'h0000, {14'h0000, busy, sensor_data_out});
		sensor_host_model_inst.command(4'h0);
		check("bad setup", 16'h0000, {14'h0000, busy, sensor_data_out});
		$display("test idle done");
	endtask
	task automatic t_cal;
		logic [3:0] code [4] = '{`SETUP_CAL_ONE, `SETUP_CAL_TWO, `SETUP_CAL_THREE, `SETUP_CAL_FOUR};
		for (int i = 0; i < 4; i++) begin
			sensor_host_model_inst.command(code[i]);
			sensor_host_model_inst.read_word(0, w);
			check("cal word", ROM[63 - 16 * i -: 16], w);
		end
		$display("test calibration done");
	endtask
	task automatic t_conv(input logic [3:0] code, input logic [15:0] val);
		int n;
		@(negedge clk);
		pressure_raw = (code == `SETUP_PRESSURE) ? val : ~val;
		temperature_raw = (code == `SETUP_PRESSURE) ? ~val : val;
		sensor_host_model_inst.resync;
		sensor_host_model_inst.command(code);
		check("ack", 16'h0003, {14'h0000, busy, sensor_data_out});
		sensor_host_model_inst.tick(1'b0);
		sensor_host_model_inst.tick(1'b0);
		n = 0;
		while (sensor_data_out !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		repeat (2) @(negedge clk);
		check("conv end", 16'h0000, {14'h0000, busy, sensor_data_out});
		sensor_host_model_inst.read_word(3000, w);
		check("result", val, w);
		$display("test conversion done");
	endtask
	task automatic t_resync;
		// Abort a running conversion, which ignores link clocks otherwise
		sensor_host_model_inst.command(`SETUP_TEMPERATURE);
		sensor_host_model_inst.tick(1'b0);
		sensor_host_model_inst.tick(1'b0);
		sensor_host_model_inst.resync;
		check("resync idle", 16'h0000, {14'h0000, busy, sensor_data_out});
		sensor_host_model_inst.command(`SETUP_CAL_FOUR);
		sensor_host_model_inst.read_word(0, w);
		check("after resync", ROM[15:0], w);
		$display("test resync done");
	endtask
	initial begin
		#1000000;
		n_fail++;
		end_of_test;
	end
	initial begin
		rst_n = 1'b0;
		pressure_raw = 16'h0000;
		temperature_raw = 16'h0000;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_idle;
		t_cal;
		t_conv(`SETUP_PRESSURE, 16'hA5C3);
		t_conv(`SETUP_TEMPERATURE, 16'h3C5A);
		t_resync;
		end_of_test;
	end
endmodule
`default_nettype wire
